// file: core/ipv4_acl_entry_match.sv
// ipv4 header match of one access-control entry, configured over apb
//
// How it works
// - ipv4 criteria count only when the entry frame type selects ipv4
// - protocol criterion any ignores the protocol field
// - protocol specific hits only when protocol equals the stored 8-bit value
// - icmp, udp and tcp choices restrict hits to that protocol
// - ttl zero rejects frames with ttl above zero; any ignores ttl
// - ttl non-zero lets frames with ttl above zero hit
// - fragment no rejects frames with more-fragments or nonzero offset
// - fragment yes lets fragmented frames hit; any ignores fragmentation
// - options no rejects frames carrying header options
// - options yes lets frames with options hit; any ignores options
// - source any ignores the source address
// - source host needs the source address equal to the stored one
// - source network compares only bits set in the source mask
// - destination any ignores the destination address
// - destination host needs an exact destination address match
// - destination network compares only bits set in the destination mask
module ipv4_acl_entry_match
	import ipv4_acl_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              frm_valid,
	input  wire logic              frm_is_ipv4,
	input  wire logic [7:0]        frm_protocol,
	input  wire logic [7:0]        frm_ttl,
	input  wire logic              frm_more_frag,
	input  wire logic [12:0]       frm_frag_offset,
	input  wire logic [3:0]        frm_hdr_len,
	input  wire logic [31:0]       frm_source_address,
	input  wire logic [31:0]       frm_destination_address,
	output logic                   hit_valid,
	output logic                   hit
);

	////////////////////////////////////////////////////////////////////////////////
	// configuration and status storage
	logic [31:0] ctrl_ff;
	logic [31:0] proto_ff;
	logic [31:0] source_address_ff;
	logic [31:0] source_mask_ff;
	logic [31:0] destination_address_ff;
	logic [31:0] destination_mask_ff;
	logic [31:0] hit_count_ff;
	logic [31:0] prdata_ff;
	logic        hit_valid_ff;
	logic        hit_ff;
	logic        last_ipv4_ff;
	logic        seen_ff;

	////////////////////////////////////////////////////////////////////////////////
	// apb decode
	wire logic        setup_ph;
	wire logic        access_ph;
	wire logic        addr_hit;
	wire logic        wr_en;
	wire logic        wr_ctrl;
	wire logic        wr_proto;
	wire logic        wr_sa;
	wire logic        wr_sm;
	wire logic        wr_da;
	wire logic        wr_dm;
	wire logic        wr_cnt;
	wire logic [31:0] status_word;
	wire logic [31:0] nxt_prdata;

	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable;
	assign addr_hit  = (paddr == CTRL_OFF) || (paddr == PROTO_OFF) ||
	                   (paddr == SRC_ADDR_OFF) || (paddr == SRC_MASK_OFF) ||
	                   (paddr == DST_ADDR_OFF) || (paddr == DST_MASK_OFF) ||
	                   (paddr == STATUS_OFF) || (paddr == HIT_COUNT_OFF);
	assign wr_en    = access_ph && pwrite && addr_hit;
	assign wr_ctrl  = wr_en && (paddr == CTRL_OFF);
	assign wr_proto = wr_en && (paddr == PROTO_OFF);
	assign wr_sa    = wr_en && (paddr == SRC_ADDR_OFF);
	assign wr_sm    = wr_en && (paddr == SRC_MASK_OFF);
	assign wr_da    = wr_en && (paddr == DST_ADDR_OFF);
	assign wr_dm    = wr_en && (paddr == DST_MASK_OFF);
	assign wr_cnt   = wr_en && (paddr == HIT_COUNT_OFF);

	// zero wait states; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = access_ph && !addr_hit;
	assign prdata  = prdata_ff;
	assign status_word = {29'h0000_0000, last_ipv4_ff, seen_ff, hit_ff};
	assign nxt_prdata = (paddr == CTRL_OFF)      ? ctrl_ff :
	                    (paddr == PROTO_OFF)     ? proto_ff :
	                    (paddr == SRC_ADDR_OFF)  ? source_address_ff :
	                    (paddr == SRC_MASK_OFF)  ? source_mask_ff :
	                    (paddr == DST_ADDR_OFF)  ? destination_address_ff :
	                    (paddr == DST_MASK_OFF)  ? destination_mask_ff :
	                    (paddr == STATUS_OFF)    ? status_word :
	                    (paddr == HIT_COUNT_OFF) ? hit_count_ff : WORD_RST;

	////////////////////////////////////////////////////////////////////////////////
	// configuration fields
	wire logic [1:0] frame_type;
	wire logic [2:0] proto_crit;
	wire logic [1:0] time_to_live_criterion;
	wire logic [1:0] frag_crit;
	wire logic [1:0] opt_crit;
	wire logic [1:0] source_crit;
	wire logic [1:0] destination_crit;
	wire logic [7:0] proto_value;

	assign frame_type             = ctrl_ff[FT_LSB +: 2];
	assign proto_crit             = ctrl_ff[PC_LSB +: 3];
	assign time_to_live_criterion = ctrl_ff[TTL_LSB +: 2];
	assign frag_crit              = ctrl_ff[FRAG_LSB +: 2];
	assign opt_crit               = ctrl_ff[OPT_LSB +: 2];
	assign source_crit            = ctrl_ff[SRC_LSB +: 2];
	assign destination_crit       = ctrl_ff[DST_LSB +: 2];
	assign proto_value            = proto_ff[7:0];

	////////////////////////////////////////////////////////////////////////////////
	// per-field results
	wire logic ttl_above_zero;
	wire logic is_fragment;
	wire logic has_options;
	wire logic proto_ok;
	wire logic ttl_ok;
	wire logic frag_ok;
	wire logic opt_ok;
	wire logic source_ok;
	wire logic destination_ok;
	wire logic fields_ok;
	wire logic ipv4_entry;
	wire logic nxt_hit;

	assign ttl_above_zero = (frm_ttl != 8'h00);
	assign is_fragment    = frm_more_frag || (frm_frag_offset != 13'h0000);
	assign has_options    = (frm_hdr_len > BASE_HDR_WORDS);

	assign proto_ok = (proto_crit == PC_ANY)      ? 1'b1 :
	                  (proto_crit == PC_SPECIFIC) ? (frm_protocol == proto_value) :
	                  (proto_crit == PC_ICMP)     ? (frm_protocol == PROTO_ICMP) :
	                  (proto_crit == PC_UDP)      ? (frm_protocol == PROTO_UDP) :
	                  (proto_crit == PC_TCP)      ? (frm_protocol == PROTO_TCP) : 1'b0;
	assign ttl_ok  = tri_ok(time_to_live_criterion, ttl_above_zero);
	assign frag_ok = tri_ok(frag_crit, is_fragment);
	assign opt_ok  = tri_ok(opt_crit, has_options);
	addr_match u_source_match (
		.crit     (source_crit),
		.cfg_addr (source_address_ff),
		.cfg_mask (source_mask_ff),
		.frm_addr (frm_source_address),
		.match    (source_ok)
	);

	addr_match u_destination_match (
		.crit     (destination_crit),
		.cfg_addr (destination_address_ff),
		.cfg_mask (destination_mask_ff),
		.frm_addr (frm_destination_address),
		.match    (destination_ok)
	);
	assign fields_ok = proto_ok && ttl_ok && frag_ok && opt_ok && source_ok && destination_ok;
	// ipv4 criteria gated by frame type
	assign ipv4_entry = (frame_type == FT_IPV4);
	assign nxt_hit    = ipv4_entry ? (frm_is_ipv4 && fields_ok) : 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff                <= CTRL_RST;
			proto_ff               <= WORD_RST;
			source_address_ff      <= WORD_RST;
			source_mask_ff         <= WORD_RST;
			destination_address_ff <= WORD_RST;
			destination_mask_ff    <= WORD_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_ff <= apply_strb(ctrl_ff, pwdata, pstrb) & CTRL_WMASK;
			if (wr_proto)
				proto_ff <= apply_strb(proto_ff, pwdata, pstrb) & PROTO_WMASK;
			if (wr_sa)
				source_address_ff <= apply_strb(source_address_ff, pwdata, pstrb);
			if (wr_sm)
				source_mask_ff <= apply_strb(source_mask_ff, pwdata, pstrb);
			if (wr_da)
				destination_address_ff <= apply_strb(destination_address_ff, pwdata, pstrb);
			if (wr_dm)
				destination_mask_ff <= apply_strb(destination_mask_ff, pwdata, pstrb);
		end
	end

	// read data captured in the setup cycle so it is a flop output in the access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= WORD_RST;
		else if (setup_ph)
			prdata_ff <= nxt_prdata;
	end

	// a hit in the clearing cycle still counts: the set wins over the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hit_count_ff <= WORD_RST;
		else if (wr_cnt)
			hit_count_ff <= (frm_valid && nxt_hit) ? COUNT_ONE : WORD_RST;
		else if (frm_valid && nxt_hit)
			hit_count_ff <= hit_count_ff + COUNT_ONE;
	end

	// result stands until the next frame
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hit_valid_ff <= 1'b0;
			hit_ff       <= 1'b0;
			last_ipv4_ff <= 1'b0;
			seen_ff      <= 1'b0;
		end
		else
		begin
			hit_valid_ff <= frm_valid;
			if (frm_valid)
			begin
				hit_ff       <= nxt_hit;
				last_ipv4_ff <= frm_is_ipv4;
				seen_ff      <= 1'b1;
			end
		end
	end
	assign hit_valid = hit_valid_ff;
	assign hit       = hit_ff;

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	non_ipv4_pass_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && (frame_type != FT_IPV4) |=> hit_valid && hit)
		else $error("entry not typed ipv4 must pass every frame");
	ipv4_type_need_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && ipv4_entry && !frm_is_ipv4 |=> !hit)
		else $error("non-ipv4 frame hit an ipv4 entry");

	proto_any_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && ipv4_entry && frm_is_ipv4 && (proto_crit == PC_ANY) &&
		ttl_ok && frag_ok && opt_ok && source_ok && destination_ok |=> hit)
		else $error("protocol any blocked a hit");

	proto_value_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && ipv4_entry && (proto_crit == PC_SPECIFIC) &&
		(frm_protocol != proto_ff[7:0]) |=> !hit)
		else $error("specific protocol mismatch still hit");

	proto_named_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && ipv4_entry && (proto_crit == PC_UDP) &&
		(frm_protocol != 8'h11) |=> !hit)
		else $error("udp entry hit a non-udp frame");

	proto_numbers_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && ((proto_crit == PC_ICMP && frm_protocol == 8'h01) ||
		(proto_crit == PC_TCP && frm_protocol == 8'h06)) |-> proto_ok)
		else $error("icmp or tcp number not recognised");

	ttl_zero_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && ipv4_entry && (time_to_live_criterion == TRI_NO) &&
		(frm_ttl > 8'h00) |=> hit_valid && !hit)
		else $error("ttl zero entry hit a frame with ttl above zero");
	ttl_nonzero_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && (time_to_live_criterion == TRI_YES) |-> (ttl_ok == (frm_ttl != 8'h00)))
		else $error("ttl non-zero result wrong");

	frag_no_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && ipv4_entry && (frag_crit == TRI_NO) &&
		(frm_more_frag || frm_frag_offset != 13'h0000) |=> !hit)
		else $error("fragment no entry hit a fragment");
	frag_yes_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && (frag_crit == TRI_YES) && !frm_more_frag &&
		(frm_frag_offset == 13'h0000) |-> !frag_ok)
		else $error("fragment yes accepted a whole frame");

	opt_no_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && ipv4_entry && (opt_crit == TRI_NO) && (frm_hdr_len > 4'h5) |=> !hit)
		else $error("options no entry hit a frame with options");
	opt_yes_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && (opt_crit == TRI_YES) |-> (opt_ok == (frm_hdr_len > 4'h5)))
		else $error("options yes result wrong");

	source_any_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && (source_crit == AC_ANY) |-> source_ok)
		else $error("source any rejected a frame");

	source_host_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && ipv4_entry && (source_crit == AC_HOST) &&
		(frm_source_address != source_address_ff) |=> !hit)
		else $error("source host mismatch still hit");
	source_net_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && (source_crit == AC_NET) |->
		(source_ok == (((frm_source_address ^ source_address_ff) & source_mask_ff) == 0)))
		else $error("source network compare wrong");

	dest_any_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && (destination_crit == AC_ANY) |-> destination_ok)
		else $error("destination any rejected a frame");

	dest_host_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && ipv4_entry && (destination_crit == AC_HOST) &&
		(frm_destination_address != destination_address_ff) |=> !hit)
		else $error("destination host mismatch still hit");
	dest_net_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && (destination_crit == AC_NET) |-> (destination_ok ==
		(((frm_destination_address ^ destination_address_ff) & destination_mask_ff) == 0)))
		else $error("destination network compare wrong");

	all_fields_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		frm_valid && ipv4_entry |=> (hit == $past(frm_is_ipv4 && proto_ok && ttl_ok &&
		frag_ok && opt_ok && source_ok && destination_ok)))
		else $error("hit is not the and of all fields");

	hit_stands_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!frm_valid |=> !hit_valid && $stable(hit))
		else $error("result changed without a frame");

endmodule : ipv4_acl_entry_match

// file: core/ipv4_acl_pkg.sv
// constants, field layout and helper functions of the ipv4 access-control entry matcher
package ipv4_acl_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFF      = 8'h00;
	localparam logic [7:0] PROTO_OFF     = 8'h04;
	localparam logic [7:0] SRC_ADDR_OFF  = 8'h08;
	localparam logic [7:0] SRC_MASK_OFF  = 8'h0c;
	localparam logic [7:0] DST_ADDR_OFF  = 8'h10;
	localparam logic [7:0] DST_MASK_OFF  = 8'h14;
	localparam logic [7:0] STATUS_OFF    = 8'h18;
	localparam logic [7:0] HIT_COUNT_OFF = 8'h1c;

	////////////////////////////////////////////////////////////////////////////////
	// reset values and writable bits
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0033_3f73;
	localparam logic [31:0] PROTO_WMASK = 32'h0000_00ff;
	localparam logic [31:0] WORD_RST   = 32'h0000_0000;
	localparam logic [31:0] COUNT_ONE  = 32'h0000_0001;

	////////////////////////////////////////////////////////////////////////////////
	// control field positions
	localparam int FT_LSB   = 0;
	localparam int PC_LSB   = 4;
	localparam int TTL_LSB  = 8;
	localparam int FRAG_LSB = 10;
	localparam int OPT_LSB  = 12;
	localparam int SRC_LSB  = 16;
	localparam int DST_LSB  = 20;

	// frame type of the entry
	localparam logic [1:0] FT_ANY  = 2'h0;
	localparam logic [1:0] FT_IPV4 = 2'h1;

	// protocol criterion
	localparam logic [2:0] PC_ANY      = 3'h0;
	localparam logic [2:0] PC_SPECIFIC = 3'h1;
	localparam logic [2:0] PC_ICMP     = 3'h2;
	localparam logic [2:0] PC_UDP      = 3'h3;
	localparam logic [2:0] PC_TCP      = 3'h4;

	// three-way criterion: ttl uses no as zero and yes as non-zero
	localparam logic [1:0] TRI_ANY = 2'h0;
	localparam logic [1:0] TRI_NO  = 2'h1;
	localparam logic [1:0] TRI_YES = 2'h2;

	// address criterion
	localparam logic [1:0] AC_ANY  = 2'h0;
	localparam logic [1:0] AC_HOST = 2'h1;
	localparam logic [1:0] AC_NET  = 2'h2;

	// protocol numbers and header length limit
	localparam logic [7:0] PROTO_ICMP  = 8'h01;
	localparam logic [7:0] PROTO_TCP   = 8'h06;
	localparam logic [7:0] PROTO_UDP   = 8'h11;
	localparam logic [3:0] BASE_HDR_WORDS = 4'h5;

	////////////////////////////////////////////////////////////////////////////////
	// reserved codes never hit
	function automatic logic tri_ok(input logic [1:0] crit, input logic flag);
		case (crit)
			TRI_ANY: tri_ok = 1'b1;
			TRI_NO:  tri_ok = !flag;
			TRI_YES: tri_ok = flag;
			default: tri_ok = 1'b0;
		endcase
	endfunction : tri_ok

	function automatic logic [31:0] apply_strb(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = new_val[i*8 +: 8];
		end
		apply_strb = res;
	endfunction : apply_strb

endpackage : ipv4_acl_pkg

// file: core/addr_match.sv
// one address criterion: any, exact host or masked network compare
module addr_match
	import ipv4_acl_pkg::*;
(
	input  wire logic [1:0]  crit,
	input  wire logic [31:0] cfg_addr,
	input  wire logic [31:0] cfg_mask,
	input  wire logic [31:0] frm_addr,
	output logic             match
);

	wire logic [31:0] diff;
	wire logic        host_eq;
	wire logic        net_eq;

	assign diff    = cfg_addr ^ frm_addr;
	assign host_eq = (diff == 32'h0000_0000);
	// bits outside the mask never matter
	assign net_eq  = ((diff & cfg_mask) == 32'h0000_0000);

	assign match = (crit == AC_ANY)  ? 1'b1 :
	               (crit == AC_HOST) ? host_eq :
	               (crit == AC_NET)  ? net_eq : 1'b0;

endmodule : addr_match

// file: dv/frame_source.sv
// frame parser model presenting ipv4 headers to the entry matcher
module frame_source
(
	input  wire logic        pclk,
	output logic             frm_valid,
	output logic             frm_is_ipv4,
	output logic [7:0]       frm_protocol,
	output logic [7:0]       frm_ttl,
	output logic             frm_more_frag,
	output logic [12:0]      frm_frag_offset,
	output logic [3:0]       frm_hdr_len,
	output logic [31:0]      frm_source_address,
	output logic [31:0]      frm_destination_address
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		frm_valid = 1'b0;
		{frm_is_ipv4, frm_protocol, frm_ttl, frm_more_frag, frm_frag_offset, frm_hdr_len,
			frm_source_address, frm_destination_address} = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// fields mean nothing outside the strobe: invert them so no stale value can hit
	task automatic send(input logic v4, input logic [7:0] pr, input logic [7:0] tl,
		input logic mf, input logic [12:0] fo, input logic [3:0] hl,
		input logic [31:0] sa, input logic [31:0] da);
		@(posedge pclk);
		frm_valid <= 1'b1;
		{frm_is_ipv4, frm_protocol, frm_ttl, frm_more_frag, frm_frag_offset, frm_hdr_len,
			frm_source_address, frm_destination_address} <= {v4, pr, tl, mf, fo, hl, sa, da};
		@(posedge pclk);
		frm_valid <= 1'b0;
		{frm_is_ipv4, frm_protocol, frm_ttl, frm_more_frag, frm_frag_offset, frm_hdr_len,
			frm_source_address, frm_destination_address} <= ~{v4, pr, tl, mf, fo, hl, sa, da};
	endtask : send
endmodule : frame_source

// file: dv/ipv4_acl_entry_match_bench.sv
// self-checking bench of the ipv4 access-control entry matcher
module ipv4_acl_entry_match_bench
	import ipv4_acl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hit_valid, hit;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic        frm_valid, frm_is_ipv4, frm_more_frag;
	logic [7:0]  frm_protocol, frm_ttl;
	logic [12:0] frm_frag_offset;
	logic [3:0]  frm_hdr_len;
	logic [31:0] frm_source_address, frm_destination_address;
	int          errors, checked, cycles;
	logic        f_v4, f_mf;
	logic [7:0]  f_pr, f_tl;
	logic [12:0] f_fo;
	logic [3:0]  f_hl;
	logic [31:0] f_sa, f_da;

	ipv4_acl_entry_match i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .frm_valid, .frm_is_ipv4, .frm_protocol, .frm_ttl,
		.frm_more_frag, .frm_frag_offset, .frm_hdr_len, .frm_source_address,
		.frm_destination_address, .hit_valid, .hit);
	frame_source i_src (.pclk, .frm_valid, .frm_is_ipv4, .frm_protocol, .frm_ttl,
		.frm_more_frag, .frm_frag_offset, .frm_hdr_len, .frm_source_address,
		.frm_destination_address);

	always #2.5 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// about 60 frames and 70 bus transfers, some 330 clocks; a wide margin still ends a hang quickly
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0000_0000, rd, err);
		check(rd, exp);
		check(err, exp_err);
	endtask : rdchk

	function automatic logic [31:0] cf(input logic [2:0] code, input int lsb);
		cf = (32'(code) << lsb) | 32'(FT_IPV4);
	endfunction : cf

	// clean unfragmented ipv4 tcp header without options
	task automatic clean;
		{f_v4, f_pr, f_tl, f_mf, f_fo, f_hl} = {1'b1, 8'h06, 8'h40, 1'b0, 13'h0000, 4'h5};
		f_sa = 32'hc0a8_0101;
		f_da = f_sa;
	endtask : clean

	task automatic try(input logic [31:0] ctrl, input logic exp);
		wr(CTRL_OFF, ctrl);
		i_src.send(f_v4, f_pr, f_tl, f_mf, f_fo, f_hl, f_sa, f_da);
		#1;
		check(hit_valid, 1'b1);
		check(hit, exp);
	endtask : try

	// any always hits, no hits without the flag, yes only with it, reserved code never
	task automatic tri3(input int lsb, input logic flag);
		try(cf(TRI_ANY, lsb), 1'b1);
		try(cf(TRI_NO, lsb), !flag);
		try(cf(TRI_YES, lsb), flag);
		try(cf(3'h3, lsb), 1'b0);
	endtask : tri3

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rdchk(CTRL_OFF, CTRL_RST, 1'b0);
		rdchk(HIT_COUNT_OFF, WORD_RST, 1'b0);
		wr(CTRL_OFF, 32'hffff_ffff);
		rdchk(CTRL_OFF, CTRL_WMASK, 1'b0);
		wr(STATUS_OFF, 32'hffff_ffff);
		rdchk(STATUS_OFF, WORD_RST, 1'b0);
		rdchk(8'h20, 32'h0000_0000, 1'b1);
	endtask : t_regs

	task automatic t_frame_type;
		clean();
		try(32'(PC_ICMP) << PC_LSB, 1'b1);
		f_v4 = 1'b0;
		try(32'(PC_ICMP) << PC_LSB, 1'b1);
		try(cf(PC_ANY, PC_LSB), 1'b0);
	endtask : t_frame_type

	task automatic t_protocol;
		logic [2:0] crit [4] = '{PC_SPECIFIC, PC_ICMP, PC_UDP, PC_TCP};
		logic [7:0] num [4] = '{8'hff, 8'h01, 8'h11, 8'h06};
		clean();
		wr(PROTO_OFF, 32'h0000_00ff);
		for (int i = 0; i < 4; i++)
		begin
			f_pr = num[i];
			try(cf(crit[i], PC_LSB), 1'b1);
			f_pr = num[i] ^ 8'h02;
			try(cf(crit[i], PC_LSB), 1'b0);
		end
		try(cf(PC_ANY, PC_LSB), 1'b1);
		try(cf(3'h5, PC_LSB), 1'b0);
	endtask : t_protocol

	task automatic t_fields;
		clean();
		f_tl = 8'h00;
		tri3(TTL_LSB, 1'b0);
		f_tl = 8'h01;
		tri3(TTL_LSB, 1'b1);
		clean();
		f_mf = 1'b1;
		tri3(FRAG_LSB, 1'b1);
		f_mf = 1'b0;
		f_fo = 13'h0001;
		tri3(FRAG_LSB, 1'b1);
		f_fo = 13'h0000;
		tri3(FRAG_LSB, 1'b0);
		f_hl = 4'h6;
		tri3(OPT_LSB, 1'b1);
		f_hl = 4'h5;
		tri3(OPT_LSB, 1'b0);
	endtask : t_fields

	// source mask keeps 24 bits, destination mask 16, so bit 8 tells them apart
	task automatic t_addr;
		int lsb;
		clean();
		wr(SRC_ADDR_OFF, 32'hc0a8_0101);
		wr(SRC_MASK_OFF, 32'hffff_ff00);
		wr(DST_ADDR_OFF, 32'hc0a8_0101);
		wr(DST_MASK_OFF, 32'hffff_0000);
		for (int j = 0; j < 2; j++)
		begin
			lsb = j ? DST_LSB : SRC_LSB;
			f_sa = 32'hc0a8_0101;
			f_da = f_sa;
			try(cf(AC_HOST, lsb), 1'b1);
			f_sa = 32'hc0a8_01fe;
			f_da = f_sa;
			try(cf(AC_HOST, lsb), 1'b0);
			try(cf(AC_NET, lsb), 1'b1);
			f_sa = 32'hc0a8_0001;
			f_da = f_sa;
			try(cf(AC_NET, lsb), j[0]);
			f_sa = 32'hc0a9_0101;
			f_da = f_sa;
			try(cf(AC_NET, lsb), 1'b0);
			try(cf(AC_ANY, lsb), 1'b1);
			try(cf(3'h3, lsb), 1'b0);
		end
	endtask : t_addr

	task automatic t_count;
		clean();
		wr(HIT_COUNT_OFF, 32'h0000_0000);
		try(cf(PC_ANY, PC_LSB), 1'b1);
		rdchk(HIT_COUNT_OFF, COUNT_ONE, 1'b0);
		rdchk(STATUS_OFF, 32'h0000_0007, 1'b0);
	endtask : t_count

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{errors, checked, cycles} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_frame_type();
		t_protocol();
		t_fields();
		t_addr();
		t_count();
		print_verdict();
	end
endmodule : ipv4_acl_entry_match_bench
